// File: core/obr_pkg.sv
package obr_pkg;

  // core data space decode
  localparam logic [7:0] PAGE_REG_ADDR = 8'he8;
  localparam logic [7:0] PAGE_LINES_1_4 = 8'h20;
  localparam logic [7:0] PAGE_LINE_5 = 8'h40;
  localparam logic [7:0] GLYPH_BANK_ADDR = 8'hed;
  localparam logic [7:0] SYNC_PORT_ADDR = 8'he4;
  localparam int SYNC_PORT_BIT = 4;
  localparam logic [5:0] BACKDROP_OFS = 6'h14;
  localparam logic [5:0] MASTER_ON_OFS = 6'h17;
  localparam logic [5:0] LINE5_TOP_OFS = 6'h0f;
  localparam logic [6:0] LINE5_BASE = 7'h40;

  // display ram geometry
  localparam int RAM_DEPTH = 80;
  localparam int ENTRY_W = 7;
  localparam int GLYPH_TYPES = 64;
  localparam int COLS = 16;
  localparam int LINES = 5;

  // pixel timing: one dot every DOT_DIV core cycles once the oscillator runs
  localparam logic [3:0] DOT_DIV = 4'h8;
  localparam logic [2:0] DOTS_PER_CELL = 3'h6;

  // reset values of control state
  localparam logic [7:0] BACKDROP_RST = 8'h00;
  localparam logic [5:0] COLOUR_BLACK = 6'h00;

  // entry layout: bit 6 set marks a space entry, else low six bits index a glyph; column 0 is always the format entry
  localparam int ENT_CTRL_BIT = 6;
  localparam int ENT_BGS_BIT = 5;
  localparam int ENT_WORD_ON_BIT = 4;
  localparam int ENT_GAP_BIT = 3;
  localparam int ENT_SIZE_BIT = 2;
  localparam int ENT_COLOUR_LSB = 0;

  // write strobe with its data from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } obr_wr_t;

  // the four video outputs
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic blank;
  } obr_video_t;

  typedef enum logic [1:0] {OSC_OFF, OSC_WAIT_VS, OSC_RUN} obr_osc_t;

endpackage

// File: core/obr_sync_in.sv
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser with a combinational rising-edge detector against a third flop after it
module obr_sync_in
  import obr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta;
  logic stage2;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pin;
      stage2 <= meta;
      level <= stage2;
    end
  end

  // edge taken past the second flop, so the first flop feeds nothing else
  always_comb rise = stage2 & ~level;

endmodule
`default_nettype wire

// File: core/obr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - backdrop setup at page 6 offset 14h: colour pairs bits 7..2, enables bits 1..0
// - two backdrop definitions; preceding entry's choice bit picks one per word
// - backdrop colour is a three-bit red/green/blue code, black to white
// - backdrop enable 0 draws word bare, 1 surrounds word with backdrop
// - glyph bank register at EDh, no page, write-only, bit 0 picks bank
// - glyph bank change accepted only while display master enable is clear
// - core reaches display ram only while master enable is zero
// - first entry per line is hidden format: size, line gap, first word attributes
// - later entries are space entries or an index to 64 glyph types
// - space entry sets colour, backdrop, word enable, word gap for next word; code takes the gap bit from the format entry only
// - ram holds 80 seven-bit entries: five lines of sixteen
// - address bits 3..0 column, 5..4 line on page 5; line 5 page 6 00h-0Fh
// - all 86 display locations are write-only, no read-back
// - master enable at 17h writable always; other 85 only while oscillator stopped
// - after master enable is set, oscillator waits for next vertical sync
// - clearing master enable stops the oscillator at once
// - vertical sync pin readable inverted as bit 4 of E4h
// - generator locks to vertical and horizontal sync, drives four video outputs
// - box mode: space at line end, size 0, spaces unbacked gives end bar
// - enable clear: display off, core writes; set: words shown, core locked
// - blank-gap backdrop-off 0 follows enables; 1 no backdrop on spaces
module obr_ctrl
  import obr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire obr_wr_t core_wr,
  input wire logic [7:0] core_rd_addr,
  output logic [7:0] core_rd_data,
  input wire logic vsync_pin,
  input wire logic hsync_pin,
  input wire logic blank_gap_backdrop_off,
  input wire logic box_backdrop_mode,
  output var obr_video_t video,
  output logic display_master_on,
  output logic osc_running,
  output logic glyph_bank_pick
);

  // synchronised sync pins
  logic vs_level, vs_rise, hs_rise;
  obr_sync_in u_vs (
    .core_clk(core_clk),
    .reset(reset),
    .pin(vsync_pin),
    .level(vs_level),
    .rise(vs_rise)
  );
  obr_sync_in u_hs (
    .core_clk(core_clk),
    .reset(reset),
    .pin(hsync_pin),
    .level(),
    .rise(hs_rise)
  );

  // ---- core write decode ----
  logic [7:0] page;
  logic [7:0] backdrop_setup_reg;
  logic [ENTRY_W-1:0] disp_ram [RAM_DEPTH];
  obr_osc_t osc_state;
  logic [7:0] next_page, next_backdrop;
  logic next_master, next_bank;
  logic in_page5, in_page6, open_wr, ram_we;
  logic [6:0] ram_waddr;

  always_comb begin
    in_page5 = core_wr.addr[7:6] == 2'b00 && page == PAGE_LINES_1_4;
    in_page6 = core_wr.addr[7:6] == 2'b00 && page == PAGE_LINE_5;
    open_wr = core_wr.wr && osc_state == OSC_OFF && !display_master_on;
    next_page = core_wr.wr && core_wr.addr == PAGE_REG_ADDR ? core_wr.data : page;
    next_master = display_master_on;
    if (core_wr.wr && in_page6 && core_wr.addr[5:0] == MASTER_ON_OFS) begin
      next_master = core_wr.data[0];
    end
    next_backdrop = backdrop_setup_reg;
    if (open_wr && in_page6 && core_wr.addr[5:0] == BACKDROP_OFS) begin
      next_backdrop = core_wr.data;
    end
    next_bank = glyph_bank_pick;
    if (open_wr && core_wr.addr == GLYPH_BANK_ADDR) begin
      next_bank = core_wr.data[0];
    end
    ram_we = 1'b0;
    ram_waddr = 7'h00;
    if (open_wr && in_page5) begin
      ram_we = 1'b1; // lines 1..4 by address bits 5..4
      ram_waddr = {1'b0, core_wr.addr[5:0]};
    end else if (open_wr && in_page6 && core_wr.addr[5:0] <= LINE5_TOP_OFS) begin
      ram_we = 1'b1; // line 5
      ram_waddr = LINE5_BASE | {3'b000, core_wr.addr[3:0]};
    end
  end

  // bank holds no reset value by design; everything else is cleared
  always_ff @(posedge core_clk) begin
    glyph_bank_pick <= next_bank;
    if (reset) begin
      page <= 8'h00;
      backdrop_setup_reg <= BACKDROP_RST;
      display_master_on <= 1'b0;
    end else begin
      page <= next_page;
      backdrop_setup_reg <= next_backdrop;
      display_master_on <= next_master;
    end
  end

  // 80 x 7 entries; write port only from the core
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      disp_ram[ram_waddr] <= core_wr.data[ENTRY_W-1:0];
    end
  end

  // read side: only the sync port bit, display locations read zero
  logic [7:0] next_rd;
  always_comb begin
    next_rd = 8'h00;
    if (core_rd_addr == SYNC_PORT_ADDR) begin
      next_rd[SYNC_PORT_BIT] = ~vs_level;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) core_rd_data <= 8'h00;
    else core_rd_data <= next_rd;
  end

  // ---- oscillator start/stop ----
  obr_osc_t next_osc;
  always_comb begin
    next_osc = osc_state;
    unique case (osc_state)
      OSC_OFF: if (display_master_on) next_osc = OSC_WAIT_VS;
      OSC_WAIT_VS: if (vs_rise) next_osc = OSC_RUN;
      OSC_RUN: next_osc = OSC_RUN;
    endcase
    if (!display_master_on) next_osc = OSC_OFF;
  end
  // running flag registered alongside the state so the output leaves a flop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_state <= OSC_OFF;
      osc_running <= 1'b0;
    end else begin
      osc_state <= next_osc;
      osc_running <= next_osc == OSC_RUN;
    end
  end

  // scan engine, locked to hsync/vsync
  logic [3:0] dot_div;
  logic [2:0] dot_cnt;
  logic [3:0] col;
  logic [2:0] line;
  logic cur_bgs, cur_word_on, line_size, line_gap, cur_is_space, last_space;
  logic [2:0] cur_colour;
  logic [3:0] next_div, next_col;
  logic [2:0] next_dot, next_line, next_colour;
  logic next_bgs, next_word_on, next_size, next_gap, next_is_space, next_last;
  logic [ENTRY_W-1:0] ent;
  logic [6:0] rd_idx;
  logic dot_tick;

  always_comb begin
    rd_idx = {line, col};
    ent = disp_ram[rd_idx];
    dot_tick = osc_running && dot_div == DOT_DIV - 4'h1;
    next_div = osc_running && !dot_tick ? dot_div + 4'h1 : 4'h0;
    next_dot = dot_cnt;
    next_col = col;
    next_line = line;
    next_bgs = cur_bgs;
    next_word_on = cur_word_on;
    next_size = line_size;
    next_gap = line_gap;
    next_colour = cur_colour;
    next_is_space = cur_is_space;
    next_last = last_space;
    if (!osc_running || vs_rise) begin
      next_dot = 3'h0;
      next_col = 4'h0;
      next_line = 3'h0;
    end else if (hs_rise) begin
      next_dot = 3'h0;
      next_col = 4'h0;
    end else if (dot_tick && dot_cnt == DOTS_PER_CELL - 3'h1) begin
      next_dot = 3'h0;
      if (col == 4'h0 || ent[ENT_CTRL_BIT]) begin
        // format (col 0) or space entry: attributes for the next word
        next_bgs = ent[ENT_BGS_BIT];
        next_word_on = ent[ENT_WORD_ON_BIT];
        next_colour = {1'b0, ent[1:0]};
        if (col == 4'h0) begin
          next_size = ent[ENT_SIZE_BIT];
          next_gap = ent[ENT_GAP_BIT];
        end
      end
      next_is_space = col != 4'h0 && ent[ENT_CTRL_BIT];
      if (col == 4'(COLS - 1)) next_last = next_is_space;
      if (col != 4'(COLS - 1)) next_col = col + 4'h1;
      else if (line != 3'(LINES - 1)) next_line = line + 3'h1;
    end else if (dot_tick) begin
      next_dot = dot_cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dot_div <= 4'h0;
      dot_cnt <= 3'h0;
      col <= 4'h0;
      line <= 3'h0;
      cur_bgs <= 1'b0;
      cur_word_on <= 1'b0;
      line_size <= 1'b0;
      line_gap <= 1'b0;
      cur_colour <= 3'h0;
      cur_is_space <= 1'b0;
      last_space <= 1'b0;
    end else begin
      dot_div <= next_div;
      dot_cnt <= next_dot;
      col <= next_col;
      line <= next_line;
      cur_bgs <= next_bgs;
      cur_word_on <= next_word_on;
      line_size <= next_size;
      line_gap <= next_gap;
      cur_colour <= next_colour;
      cur_is_space <= next_is_space;
      last_space <= next_last;
    end
  end

  // ---- backdrop selection and video output ----
  logic [2:0] bd_colour;
  logic bd_on, end_bar;
  obr_video_t next_video;
  always_comb begin
    // two-bit pairs collapse to one bit per gun, top bit of pair for backdrop 1
    bd_colour = cur_bgs ? {backdrop_setup_reg[7], backdrop_setup_reg[5], backdrop_setup_reg[3]}
                        : {backdrop_setup_reg[6], backdrop_setup_reg[4], backdrop_setup_reg[2]};
    bd_on = cur_bgs ? backdrop_setup_reg[1] : backdrop_setup_reg[0];
    if (cur_is_space && blank_gap_backdrop_off) bd_on = 1'b0;
    // end-of-line bar in box mode
    end_bar = box_backdrop_mode && last_space && !line_size && blank_gap_backdrop_off
              && col == 4'h0;
    next_video = '0;
    if (osc_running && cur_word_on && col != 4'h0 && (bd_on || end_bar)) begin
      next_video = '{red: bd_colour[2], green: bd_colour[1], blue: bd_colour[0], blank: 1'b1};
    end else if (osc_running && end_bar) begin
      next_video = '{red: bd_colour[2], green: bd_colour[1], blue: bd_colour[0], blank: 1'b1};
    end else if (osc_running && cur_word_on && !cur_is_space && col != 4'h0) begin
      next_video = '{red: cur_colour[2], green: cur_colour[1], blue: cur_colour[0],
                     blank: 1'b1};
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) video <= '0;
    else video <= next_video;
  end

  // ---- assertions ----
  osc_waits_vs_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(display_master_on) |=> !osc_running)
    else $error("oscillator started without vsync");
  osc_stops_a: assert property (@(posedge core_clk) disable iff (reset)
    !display_master_on |=> !osc_running)
    else $error("oscillator kept running after enable cleared");
  ram_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    ram_we |-> !display_master_on && !osc_running)
    else $error("ram written while display enabled");
  bank_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    display_master_on |=> $stable(glyph_bank_pick))
    else $error("glyph bank changed while enabled");
  backdrop_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    display_master_on ##1 display_master_on |-> $stable(backdrop_setup_reg))
    else $error("backdrop register changed while locked");
  master_write_a: assert property (@(posedge core_clk) disable iff (reset)
    core_wr.wr && in_page6 && core_wr.addr[5:0] == MASTER_ON_OFS
    |=> display_master_on == $past(core_wr.data[0]))
    else $error("master enable write lost");
  sync_port_a: assert property (@(posedge core_clk) disable iff (reset)
    core_rd_addr == SYNC_PORT_ADDR |=> core_rd_data[SYNC_PORT_BIT] == !$past(vs_level))
    else $error("sync port bit not inverted pin");
  dark_when_off_a: assert property (@(posedge core_clk) disable iff (reset)
    !osc_running ##1 !osc_running |-> video == '0)
    else $error("video active with oscillator off");
  bare_word_a: assert property (@(posedge core_clk) disable iff (reset)
    osc_running && cur_word_on && col != 4'h0 && !cur_is_space && !bd_on && !end_bar
    |=> {video.red, video.green, video.blue} == $past(cur_colour) && video.blank)
    else $error("bare word not drawn in its own colour");
  start_c: cover property (@(posedge core_clk) disable iff (reset)
    display_master_on ##[1:1000] osc_running);
  ram_wr_c: cover property (@(posedge core_clk) disable iff (reset) ram_we);
  blank_c: cover property (@(posedge core_clk) disable iff (reset) video.blank);
  bank_wr_c: cover property (@(posedge core_clk) disable iff (reset)
    open_wr && core_wr.addr == GLYPH_BANK_ADDR);

endmodule
`default_nettype wire

// File: verif/obr_tv_sync.sv
`timescale 1ns/10ps
`default_nettype none
// far-side sync source: free-running line sync, frame sync pulse on request
module obr_tv_sync (
  input wire logic core_clk,
  input wire logic vs_req,
  input wire logic [7:0] vs_len,
  output logic vsync,
  output logic hsync
);
  int hcnt = 0;
  int vcnt = 0;

  initial begin
    vsync = 1'b0;
    hsync = 1'b0;
  end

  // levels move on the falling edge so the synchroniser never samples a change
  // vs_len sets the pulse length, so a frame sync can be short or long
  always @(negedge core_clk) begin
    hcnt <= (hcnt + 1) % 64;
    hsync <= (hcnt < 4);
    if (vs_req && vcnt == 0) begin
      vcnt <= int'(vs_len);
    end else if (vcnt > 0) begin
      vcnt <= vcnt - 1;
    end
    vsync <= (vcnt != 0);
  end
endmodule
`default_nettype wire

// File: verif/tb_obr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_obr_ctrl;
  import obr_pkg::*;
  logic core_clk;
  logic reset;
  obr_wr_t core_wr;
  logic [7:0] core_rd_addr;
  logic [7:0] core_rd_data;
  logic vsync_pin;
  logic hsync_pin;
  logic blank_gap_backdrop_off;
  logic box_backdrop_mode;
  obr_video_t video;
  logic display_master_on;
  logic osc_running;
  logic glyph_bank_pick;
  logic vs_req;
  logic [7:0] vs_len;
  logic [31:0] lfsr = 32'haa56;
  int err_count = 0;
  int checked = 0;
  // reference state: page, master enable, oscillator (0 off, 1 waiting, 2 running), bank
  int m_page = 0;
  int m_on = 0;
  int m_osc = 0;
  int m_bank = -1;
  // reference backdrop setup and the one entry pattern written to every location
  logic [7:0] m_bcr = 8'h00;
  logic [6:0] m_ent = 7'h00;

  obr_ctrl obr_ctrl_i (
    .core_clk(core_clk),
    .reset(reset),
    .core_wr(core_wr),
    .core_rd_addr(core_rd_addr),
    .core_rd_data(core_rd_data),
    .vsync_pin(vsync_pin),
    .hsync_pin(hsync_pin),
    .blank_gap_backdrop_off(blank_gap_backdrop_off),
    .box_backdrop_mode(box_backdrop_mode),
    .video(video),
    .display_master_on(display_master_on),
    .osc_running(osc_running),
    .glyph_bank_pick(glyph_bank_pick)
  );

  obr_tv_sync obr_tv_sync_i (
    .core_clk(core_clk),
    .vs_req(vs_req),
    .vs_len(vs_len),
    .vsync(vsync_pin),
    .hsync(hsync_pin)
  );

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_state();
    cmp1("display_master_on", 1'(m_on), display_master_on);
    cmp1("osc_running", 1'(m_osc == 2), osc_running);
    if (m_bank >= 0) cmp1("glyph_bank_pick", 1'(m_bank), glyph_bank_pick);
    if (m_osc == 0) cmp8("video", 8'h00, {4'h0, video});
  endtask

  // whole-byte write, one-cycle strobe; the model lets through what the lock allows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_wr = '{wr: 1'b1, addr: a, data: d}; // full bytes only
    @(negedge core_clk);
    core_wr.wr = 1'b0;
    if (a == PAGE_REG_ADDR) begin
      m_page = int'(d);
    end else if (m_page == int'(PAGE_LINE_5) && a == {2'b00, MASTER_ON_OFS}) begin
      m_on = int'(d[0]);
      m_osc = !d[0] ? 0 : (m_osc == 0 ? 1 : m_osc);
    end else if (m_on == 0 && m_osc == 0 && a == GLYPH_BANK_ADDR) begin
      m_bank = int'(d[0]);
    end else if (m_on == 0 && m_osc == 0 && m_page == int'(PAGE_LINE_5)
                 && a == {2'b00, BACKDROP_OFS}) begin
      m_bcr = d;
    end
    @(negedge core_clk);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge core_clk);
      check_state();
    end
  endtask

  // colour of a shown word: backdrop pair bit picked by the choice bit, else entry colour
  function automatic logic [3:0] exp_video();
    logic b;
    b = m_ent[ENT_BGS_BIT];
    if (m_bcr[b]) return {m_bcr[6 + b], m_bcr[4 + b], m_bcr[2 + b], 1'b1};
    return {1'b0, m_ent[1:0], 1'b1};
  endfunction

  // one frame sync pulse; a waiting oscillator must start three sync flops after it
  task automatic frame(input int len);
    int seen = 0;
    vs_len <= 8'(len);
    vs_req <= 1'b1;
    @(negedge core_clk);
    vs_req <= 1'b0;
    for (int i = 0; i < len + 140; i++) begin
      @(negedge core_clk);
      if (m_osc == 1 && i == 3) m_osc = 2;
      cmp1("osc_running", 1'(m_osc == 2), osc_running);
      if (m_osc == 2 && video !== 4'h0) begin
        seen++;
        cmp8("video_colour", {4'h0, exp_video()}, {4'h0, video});
      end
      if (i == 10) begin
        cmp8("sync_port_high", 8'h00, core_rd_data);
        if (m_osc == 2) cmp1("osc_start", 1'b1, osc_running);
      end
    end
    if (m_osc == 2) cmp1("video_seen", 1'b1, 1'(seen > 0));
    cmp8("sync_port_low", 8'h10, core_rd_data);
    check_state();
  endtask

  initial begin
    core_wr = '0;
    core_rd_addr = SYNC_PORT_ADDR;
    blank_gap_backdrop_off = 1'b0;
    box_backdrop_mode = 1'b0;
    vs_req = 1'b0;
    vs_len = 8'h00;
    reset = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    idle(4);
    cmp8("sync_port_idle", 8'h10, core_rd_data);
    wr(PAGE_REG_ADDR, PAGE_LINE_5);
    repeat (4) begin
      lfsr = step(lfsr);
      wr(GLYPH_BANK_ADDR, lfsr[7:0]);
      check_state();
    end
    // write-only: nothing comes back from the backdrop setup location
    core_rd_addr = 8'h14;
    wr(8'h14, 8'hff);
    idle(2);
    cmp8("backdrop_readback", 8'h00, core_rd_data);
    core_rd_addr = SYNC_PORT_ADDR;
    // offset 17h on the lines 1-4 page is ram, not the master enable
    wr(PAGE_REG_ADDR, PAGE_LINES_1_4);
    wr(8'h17, 8'h01);
    check_state();
    // every entry gets one random pattern with the word enabled
    lfsr = step(lfsr);
    m_ent = {1'b1, lfsr[5], 1'b1, lfsr[3:0]};
    for (int k = 0; k < 64; k++) wr(8'(k), {1'b0, m_ent});
    wr(PAGE_REG_ADDR, PAGE_LINE_5);
    for (int k = 0; k < 16; k++) wr(8'(k), {1'b0, m_ent});
    wr(8'h14, lfsr[15:8]);
    repeat (3) begin
      lfsr = step(lfsr);
      blank_gap_backdrop_off = lfsr[3];
      box_backdrop_mode = lfsr[4];
      wr(8'h17, 8'h01);
      wr(GLYPH_BANK_ADDR, {7'h00, ~glyph_bank_pick});
      wr(8'h14, ~m_bcr);
      idle(20 + int'(lfsr[4:0]));
      frame(14 + int'(lfsr[9:5]));
      wr(GLYPH_BANK_ADDR, {7'h00, ~glyph_bank_pick});
      wr(8'h17, 8'h00);
      idle(1);
      frame(14);
      wr(GLYPH_BANK_ADDR, lfsr[15:8]);
      check_state();
      wr(8'h14, lfsr[23:16]);
    end
    tally_and_finish();
  end

  // guard against a hang anywhere in the sequence
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
